/* File: design/ladder_serial_port.sv */
// Operation
// [RULE_01] line rate chosen from 300 to 115200 bps table, same at both ends
// [RULE_02] fastest rate sustained is 115.2 kbps
// [RULE_03] received characters go into an 8192-byte wrapping fifo
// [RULE_04] send text sits in a buffer of at most 1792 bytes
// [RULE_05] optional start character and optional 1 or 2 terminator characters
// [RULE_06] configured terminator is appended to every sent text
// [RULE_07] text completes after 1 to 1792 received characters
// [RULE_08] inter-character gap limit 0 to 32760 ms, zero disables it
// [RULE_09] break holds the line low for 1 to 32760 ms
// [RULE_10] software data area size adjustable up to 1792 bytes
// [RULE_11] every status flag can raise the interrupt
// [RULE_12] frame: start, 7 or 8 data, parity none/even/odd, 1 or 2 stop
// [RULE_13] full or half duplex; half duplex never sends during reception (only a character start waits; a sending character or break goes on)
//
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ladder_serial_port
   import ladder_serial_pkg::*;
#(
   parameter int MS_COUNT = MS_CYCLES,
   parameter int CLOCK_HZ = CLK_HZ
) (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        we_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             irq,
   input  wire logic        rxd,
   output logic             txd,
   output logic             txDrvEn
);
   state_t     st;
   state_t     next_st;
   logic [7:0] rxRdata;
   logic [7:0] txRdata;

   // cycles per bit for the selected rate
   function automatic logic [DIVW-1:0] bitDiv(input logic [3:0] sel);
      int r;
      r = (int'(sel) >= NRATES) ? RATES[NRATES-1] : RATES[sel];
      return DIVW'(CLOCK_HZ / r);
   endfunction

   // bits per character, start bit included
   function automatic logic [3:0] frameLen(input cfg_t c);
      return 4'(2 + (c.eight ? 8 : 7) + ((c.par != PAR_NONE) ? 1 : 0)
                + (c.twoStop ? 1 : 0));
   endfunction

   function automatic logic parityOf(input cfg_t c, input logic [7:0] d);
      logic p;
      p = ^(c.eight ? d : {1'b0, d[6:0]});
      return (c.par == PAR_ODD) ? ~p : p;
   endfunction

   // character frame, sent lsb first, padded with stop level
   function automatic logic [11:0] txFrame(input cfg_t c, input logic [7:0] d);
      logic [11:0] f;
      f = '1;
      f[0] = 1'b0;
      if (c.eight) begin
         f[8:1] = d;
         if (c.par != PAR_NONE) f[9] = parityOf(c, d);
      end else begin
         f[7:1] = d[6:0];
         if (c.par != PAR_NONE) f[8] = parityOf(c, d);
      end
      return f;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return (o & ~m) | (d & m);
   endfunction

   // receive fifo and send text buffer
   simple_dp_ram #(.W(8), .DEPTH(RX_DEPTH)) rxMem (
      .clk   (core_clk),
      .we    (st.rxWe),
      .waddr (st.rxWa),
      .wdata (st.rxWd),
      .raddr (st.rxRd),
      .rdata (rxRdata)
   );
   simple_dp_ram #(.W(8), .DEPTH(TX_DEPTH)) txMem (
      .clk   (core_clk),
      .we    (st.txWe),
      .waddr (st.txWa),
      .wdata (st.txWd),
      .raddr (st.txIdx),
      .rdata (txRdata)
   );

   // whole next state
   always_comb begin
      logic [31:0]      wv;
      logic [NSTAT-1:0] setF;
      logic [NSTAT-1:0] clrF;
      logic             access;
      logic             txGo;
      logic             brkGo;
      logic             push;
      logic             pop;
      logic             got;
      logic             rxOk;
      logic             termHit;
      logic [11:0]      sh;
      logic [11:0]      v;
      logic [3:0]       nb;
      logic [7:0]       rb;
      logic [7:0]       tc;
      wv = '0;
      access = 1'b0;
      setF = '0;
      clrF = '0;
      txGo = 1'b0;
      brkGo = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      got = 1'b0;
      rxOk = 1'b0;
      termHit = 1'b0;
      sh = '0;
      v = '0;
      rb = '0;
      tc = '0;
      nb = frameLen(st.cfg) - 4'h1;
      next_st = st;
      next_st.ack = 1'b0;
      next_st.txWe = 1'b0;
      next_st.rxWe = 1'b0;

      // bus slave: answer on the second edge after the request
      access = cyc_i & stb_i & ~st.ack;
      next_st.wbWait = access & ~st.wbWait;
      if (access && st.wbWait) begin
         next_st.ack = 1'b1;
         next_st.dat = '0;
         case (adr_i)
            ADR_CTRL: begin
               next_st.dat = 32'(st.cfg);
               if (we_i) begin
                  wv = merge(32'(st.cfg), dat_i, sel_i);
                  next_st.cfg = cfg_t'(wv[11:0]);
                  txGo = wv[CTRL_TXGO];
                  brkGo = wv[CTRL_BRKGO];
               end
            end
            ADR_CHARS: begin
               next_st.dat = 32'(st.chars);
               wv = merge(32'(st.chars), dat_i, sel_i);
               if (we_i) next_st.chars = wv[23:0]; // RULE_05
            end
            ADR_RXLEN: begin
               next_st.dat = 32'(st.rxLen);
               wv = merge(32'(st.rxLen), dat_i, sel_i);
               if (we_i) begin
                  next_st.rxLen = (wv[10:0] > LEN_MAX) ? LEN_MAX : // RULE_07
                                  (wv[10:0] == '0) ? 11'h001 : wv[10:0];
               end
            end
            ADR_GAP: begin
               next_st.dat = 32'(st.gapLim);
               wv = merge(32'(st.gapLim), dat_i, sel_i);
               if (we_i) next_st.gapLim = wv[14:0];
            end
            ADR_BRK: begin
               next_st.dat = 32'(st.brkLim);
               wv = merge(32'(st.brkLim), dat_i, sel_i);
               if (we_i) next_st.brkLim = wv[14:0];
            end
            ADR_TXLEN: begin
               next_st.dat = 32'(st.txLen);
               wv = merge(32'(st.txLen), dat_i, sel_i);
               if (we_i) begin
                  // also rewinds the fill pointer of the text buffer
                  next_st.txLen = (wv[10:0] > LEN_MAX) ? LEN_MAX : wv[10:0]; // RULE_10
                  next_st.txWr = '0;
               end
            end
            ADR_TXDATA: begin
               if (we_i && sel_i[0] && st.txWr < LEN_MAX) begin // RULE_04
                  next_st.txWe = 1'b1;
                  next_st.txWa = st.txWr;
                  next_st.txWd = dat_i[7:0];
                  next_st.txWr = st.txWr + 11'h001;
               end
            end
            ADR_RXDATA: begin
               if (!we_i && st.rxCount != '0) begin
                  next_st.dat = 32'(rxRdata);
                  pop = 1'b1;
               end
            end
            ADR_STATUS: begin
               next_st.dat = 32'(st.status);
               if (we_i && sel_i[0]) clrF = dat_i[NSTAT-1:0];
            end
            ADR_MASK: begin
               next_st.dat = 32'(st.mask);
               wv = merge(32'(st.mask), dat_i, sel_i);
               if (we_i) next_st.mask = wv[NSTAT-1:0];
            end
            ADR_LEVEL: begin
               next_st.dat = {16'h0000, st.txMode == TX_BREAK,
                              st.txMode != TX_IDLE, st.rxCount};
            end
            default: ;
         endcase
      end

      // millisecond time base
      next_st.msTick = 1'b0;
      next_st.msCnt = st.msCnt + 17'h00001;
      if (st.msCnt == MSW'(MS_COUNT - 1)) begin
         next_st.msCnt = '0;
         next_st.msTick = 1'b1;
      end

      // line input: three stages, accept once the last two agree;
      // kept inverted so the all-zero reset reads as an idle line
      next_st.rxSync = {st.rxSync[1:0], ~rxd};
      if (st.rxSync[2] == st.rxSync[1]) next_st.rxLow = st.rxSync[2];

      // receiver, samples mid bit
      case (st.rxMode)
         RX_IDLE: begin
            if (st.rxLow) begin
               next_st.rxMode = RX_START;
               next_st.rxDiv = bitDiv(st.cfg.rate) >> 1; // RULE_01
            end
         end
         RX_START: begin
            next_st.rxDiv = st.rxDiv - 19'h00001;
            if (st.rxDiv == '0) begin
               // a glitch shorter than half a bit is dropped
               next_st.rxMode = st.rxLow ? RX_DATA : RX_IDLE;
               next_st.rxDiv = bitDiv(st.cfg.rate) - 19'h00001;
               next_st.rxBit = '0;
            end
         end
         RX_DATA: begin
            next_st.rxDiv = st.rxDiv - 19'h00001;
            if (st.rxDiv == '0) begin
               sh = {~st.rxLow, st.rxShift[11:1]};
               next_st.rxShift = sh;
               next_st.rxDiv = bitDiv(st.cfg.rate) - 19'h00001;
               next_st.rxBit = st.rxBit + 4'h1;
               if (st.rxBit == nb - 4'h1) begin
                  got = 1'b1;
                  next_st.rxMode = RX_IDLE;
               end
            end
         end
         default: next_st.rxMode = RX_IDLE;
      endcase

      // check the frame; only the last stop bit is examined
      v = sh >> (4'hc - nb);
      rb = st.cfg.eight ? v[7:0] : {1'b0, v[6:0]};
      rxOk = v[nb - 4'h1] && (st.cfg.par == PAR_NONE || // RULE_12
             v[st.cfg.eight ? 8 : 7] == parityOf(st.cfg, rb));
      termHit = (st.cfg.termN == 2'h1 && rb == st.chars[15:8]) ||
                (st.cfg.termN == 2'h2 && st.rxTextCnt != '0 &&
                 st.rxPrev == st.chars[15:8] && rb == st.chars[23:16]);

      // gap monitor, counts whole ms ticks while a text is open
      if (st.inText && st.gapLim != '0 && st.msTick) begin // RULE_08
         next_st.gapMs = st.gapMs + 15'h0001;
         if (next_st.gapMs >= st.gapLim) begin
            setF[ST_GAP] = 1'b1;
            next_st.inText = 1'b0;
            next_st.rxTextCnt = '0;
            next_st.gapMs = '0;
         end
      end

      // text framing of received characters
      if (got) begin
         if (!rxOk) begin
            setF[ST_ERR] = 1'b1;
         end else if (st.cfg.startEn && !st.inText) begin
            if (rb == st.chars[7:0]) begin // RULE_05
               next_st.inText = 1'b1;
               next_st.rxTextCnt = '0;
               next_st.gapMs = '0;
            end
         end else begin
            if (st.rxCount == RX_FULL) begin
               setF[ST_OVR] = 1'b1; // newest character is lost
            end else begin
               push = 1'b1; // RULE_03
               next_st.rxWe = 1'b1;
               next_st.rxWa = st.rxWr;
               next_st.rxWd = rb;
               next_st.rxWr = st.rxWr + 13'h0001;
            end
            next_st.inText = 1'b1;
            next_st.gapMs = '0;
            next_st.rxPrev = rb;
            next_st.rxTextCnt = st.rxTextCnt + 11'h001;
            if (termHit || st.rxTextCnt + 11'h001 == st.rxLen) begin // RULE_07
               setF[ST_RXDONE] = 1'b1;
               next_st.inText = 1'b0;
               next_st.rxTextCnt = '0;
            end
         end
      end
      next_st.rxRd = st.rxRd + 13'(pop);
      next_st.rxCount = st.rxCount + 14'(push) - 14'(pop);

      // transmitter: text, then terminator, or a timed break
      case (st.txMode)
         TX_IDLE: begin
            next_st.txBit = '0;
            if (brkGo) begin
               next_st.txMode = TX_BREAK;
               next_st.txMs = '0;
               next_st.txLow = 1'b1; // RULE_09
            end else if (txGo) begin
               next_st.txMode = TX_FETCH;
               next_st.txIdx = '0;
            end
         end
         TX_FETCH: begin
            // one cycle for the buffer read; in half duplex wait while receiving
            next_st.txBit = 4'h1;
            if (st.cfg.half && st.rxMode != RX_IDLE) begin // RULE_13
               next_st.txBit = '0;
            end else if (st.txBit != '0) begin
               if (st.txIdx == st.txLen + 11'(st.cfg.termN)) begin // RULE_06
                  next_st.txMode = TX_IDLE;
                  setF[ST_TXDONE] = 1'b1;
               end else begin
                  tc = (st.txIdx < st.txLen) ? txRdata :
                       (st.txIdx == st.txLen) ? st.chars[15:8] :
                       st.chars[23:16];
                  next_st.txShift = txFrame(st.cfg, tc); // RULE_12
                  next_st.txLow = 1'b1;
                  next_st.txBit = '0;
                  next_st.txDiv = bitDiv(st.cfg.rate) - 19'h00001;
                  next_st.txMode = TX_SHIFT;
               end
            end
         end
         TX_SHIFT: begin
            next_st.txDiv = st.txDiv - 19'h00001;
            if (st.txDiv == '0) begin
               next_st.txShift = {1'b1, st.txShift[11:1]};
               next_st.txLow = ~st.txShift[1];
               next_st.txBit = st.txBit + 4'h1;
               next_st.txDiv = bitDiv(st.cfg.rate) - 19'h00001;
               if (st.txBit == frameLen(st.cfg) - 4'h1) begin
                  next_st.txMode = TX_FETCH;
                  next_st.txBit = '0;
                  next_st.txIdx = st.txIdx + 11'h001;
               end
            end
         end
         TX_BREAK: begin
            if (st.msTick) begin
               next_st.txMs = st.txMs + 15'h0001;
               if (st.txMs + 15'h0001 >= st.brkLim) begin // RULE_09
                  next_st.txLow = 1'b0;
                  next_st.txMode = TX_IDLE;
                  setF[ST_BRKDONE] = 1'b1;
               end
            end
         end
         default: next_st.txMode = TX_IDLE;
      endcase

      // sticky flags, a new event wins over a clear
      next_st.status = (st.status & ~clrF) | setF; // RULE_11
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dat_o   = st.dat;
   assign ack_o   = st.ack;
   assign irq     = |(st.status & st.mask); // RULE_11
   assign txd     = ~st.txLow;
   // driver enable: always on in full duplex, only while sending in half
   assign txDrvEn = ~st.cfg.half | (st.txMode != TX_IDLE);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence frameStart;
      st.txMode != TX_SHIFT ##1 st.txMode == TX_SHIFT;
   endsequence
   sequence busReq;
      cyc_i && stb_i && !ack_o && !st.wbWait;
   endsequence

   a_break_line_low: assert property ( // RULE_09
      st.txMode == TX_BREAK |-> !txd)
      else $error("line not low during break");
   a_fifo_bound: assert property ( // RULE_03
      st.rxCount <= RX_FULL && (st.rxWr - st.rxRd) == st.rxCount[12:0])
      else $error("receive fifo count inconsistent");
   a_tx_wr_limit: assert property ( // RULE_04
      st.txWr <= LEN_MAX)
      else $error("send buffer pointer past limit");
   a_tx_len_limit: assert property ( // RULE_10
      st.txLen <= LEN_MAX && st.rxLen <= LEN_MAX)
      else $error("data area size past limit");
   a_text_len: assert property ( // RULE_07
      st.rxLen != '0 |-> st.rxTextCnt < st.rxLen)
      else $error("text count reached length without completing");
   a_half_duplex: assert property ( // RULE_13
      st.cfg.half && st.rxMode != RX_IDLE && st.txMode != TX_SHIFT
      |=> st.txMode != TX_SHIFT)
      else $error("transmit started during reception");
   a_start_bit: assert property ( // RULE_12
      frameStart |-> !txd ##1 !txd)
      else $error("frame does not open with start bit");
   a_gap_off: assert property ( // RULE_08
      st.gapLim == '0 && !st.status[ST_GAP] |=> !st.status[ST_GAP])
      else $error("gap flag raised with monitoring off");
   a_flag_irq: assert property ( // RULE_11
      $rose(st.status[ST_TXDONE]) && st.mask[ST_TXDONE] |-> irq)
      else $error("unmasked flag without interrupt");
   a_bus_answer: assert property (
      busReq |=> !ack_o ##1 ack_o ##1 !ack_o)
      else $error("bus answer not on second edge");
endmodule
`default_nettype wire

/* File: design/ladder_serial_pkg.sv */
package ladder_serial_pkg;
   // time base
   localparam int CLK_HZ    = 125_000_000;
   localparam int CLK_NS    = 8;
   localparam int MS_NS     = 1_000_000;
   localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
   localparam int MSW       = 17;
   localparam int DIVW      = 19;
   // selectable line rates, index = rate field of the control register
   localparam int NRATES        = 13;
   localparam int RATES[NRATES] = '{300, 600, 1200, 2400, 4800, 9600, 14400,
                                    19200, 28800, 38400, 57600, 76800, 115200};
   // buffers
   localparam int RX_DEPTH          = 8192;
   localparam int RXAW              = 13;
   localparam int TX_DEPTH          = 1792;
   localparam int TXAW              = 11;
   localparam logic [13:0] RX_FULL  = 14'h2000;
   localparam logic [10:0] LEN_MAX  = 11'h700;
   // word offsets
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_CHARS  = 8'h04;
   localparam logic [7:0] ADR_RXLEN  = 8'h08;
   localparam logic [7:0] ADR_GAP    = 8'h0c;
   localparam logic [7:0] ADR_BRK    = 8'h10;
   localparam logic [7:0] ADR_TXLEN  = 8'h14;
   localparam logic [7:0] ADR_TXDATA = 8'h18;
   localparam logic [7:0] ADR_RXDATA = 8'h1c;
   localparam logic [7:0] ADR_STATUS = 8'h20;
   localparam logic [7:0] ADR_MASK   = 8'h24;
   localparam logic [7:0] ADR_LEVEL  = 8'h28;
   // command bits of the control word (write only, self clearing)
   localparam int CTRL_TXGO  = 12;
   localparam int CTRL_BRKGO = 13;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ODD  = 2'h2;
   // status / mask bits
   localparam int ST_RXDONE  = 0;
   localparam int ST_GAP     = 1;
   localparam int ST_TXDONE  = 2;
   localparam int ST_BRKDONE = 3;
   localparam int ST_OVR     = 4;
   localparam int ST_ERR     = 5;
   localparam int NSTAT      = 6;

   typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_SHIFT, TX_BREAK} txMode_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rxMode_t;

   // control word bits 11:0, lsb = rate
   typedef struct packed {
      logic [1:0] termN;
      logic       startEn;
      logic       half;
      logic       twoStop;
      logic [1:0] par;
      logic       eight;
      logic [3:0] rate;
   } cfg_t;

   typedef struct packed {
      logic             ack;
      logic             wbWait;
      logic [31:0]      dat;
      cfg_t             cfg;
      logic [23:0]      chars;
      logic [10:0]      rxLen;
      logic [10:0]      txLen;
      logic [14:0]      gapLim;
      logic [14:0]      brkLim;
      logic [NSTAT-1:0] status;
      logic [NSTAT-1:0] mask;
      logic [MSW-1:0]   msCnt;
      logic             msTick;
      txMode_t          txMode;
      logic [DIVW-1:0]  txDiv;
      logic [3:0]       txBit;
      logic [11:0]      txShift;
      logic [10:0]      txIdx;
      logic [14:0]      txMs;
      logic             txLow;
      logic [10:0]      txWr;
      logic             txWe;
      logic [10:0]      txWa;
      logic [7:0]       txWd;
      logic [2:0]       rxSync;
      logic             rxLow;
      rxMode_t          rxMode;
      logic [DIVW-1:0]  rxDiv;
      logic [3:0]       rxBit;
      logic [11:0]      rxShift;
      logic             inText;
      logic [10:0]      rxTextCnt;
      logic [7:0]       rxPrev;
      logic [14:0]      gapMs;
      logic [12:0]      rxWr;
      logic [12:0]      rxRd;
      logic [13:0]      rxCount;
      logic             rxWe;
      logic [12:0]      rxWa;
      logic [7:0]       rxWd;
   } state_t;
endpackage

/* File: design/simple_dp_ram.sv */
`timescale 1ns/1ps
`default_nettype none
// one write port, one registered read port
module simple_dp_ram #(
   parameter int W     = 8,
   parameter int DEPTH = 256,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [W-1:0]  rdata
);
   logic [W-1:0] mem [DEPTH];

   // no reset on the array, so it maps to block ram
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

/* File: verification/remote_serial_end.sv */
`timescale 1ns/1ps
`default_nettype none
// far equipment: 8 data, no parity, 1 stop, fixed bit length in clocks
module remote_serial_end #(
   parameter int BITCYC = 10
) (
   input  wire logic core_clk,
   input  wire logic lineIn,
   output logic      lineOut
);
   logic [7:0] got[$];
   logic [7:0] sh;
   initial lineOut = 1'b1;
   // lsb first, called just after a rising edge
   task automatic send_byte(input logic [7:0] b);
      lineOut <= 1'b0;
      repeat (BITCYC) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         lineOut <= b[i];
         repeat (BITCYC) @(posedge core_clk);
      end
      lineOut <= 1'b1;
      repeat (BITCYC) @(posedge core_clk);
   endtask
   // mid-bit sampling; a low stop (e.g. break) drops the character
   always begin
      @(negedge lineIn);
      repeat (BITCYC / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BITCYC) @(posedge core_clk);
         sh[i] = lineIn;
      end
      repeat (BITCYC) @(posedge core_clk);
      if (lineIn === 1'b1) got.push_back(sh);
   end
endmodule
`default_nettype wire

/* File: verification/ladder_serial_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ladder_serial_port_test;
   import ladder_serial_pkg::*;
   logic        core_clk = 1'b0;
   logic        reset    = 1'b1;
   logic [7:0]  adr_i    = 8'h00;
   logic [31:0] dat_i    = 32'h0;
   logic [3:0]  sel_i    = 4'h0;
   logic        we_i     = 1'b0;
   logic        cyc_i    = 1'b0;
   logic        stb_i    = 1'b0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        irq;
   logic        rxd;
   logic        txd;
   logic        txDrvEn;
   logic [31:0] r;
   logic [7:0]  t;
   logic [7:0]  q[$];
   int          n_fail    = 0;
   int          tests_run = 0;
   int          rnd;
   always #4 core_clk = ~core_clk;
   // 1152000 Hz gives 10 clocks per bit at the top rate
   ladder_serial_port #(.MS_COUNT(50), .CLOCK_HZ(1152000)) DUT (
      .core_clk(core_clk), .reset(reset), .adr_i(adr_i), .dat_i(dat_i),
      .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .dat_o(dat_o), .ack_o(ack_o), .irq(irq), .rxd(rxd), .txd(txd),
      .txDrvEn(txDrvEn));
   remote_serial_end #(.BITCYC(10)) peer (
      .core_clk(core_clk), .lineIn(txd), .lineOut(rxd));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e,
                      input string m);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   // classic cycle; ack is sampled at the edge, release follows it
   task automatic wb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] rd);
      int n;
      @(posedge core_clk);
      adr_i <= a; we_i <= w; dat_i <= d; sel_i <= 4'hf;
      cyc_i <= 1'b1; stb_i <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
      if (n >= 50) begin
         chk(0, 1, "no ack");
         stop_test();
      end
   endtask
   // status polling bounded, then w1c clear of that bit
   task automatic poll(input int i);
      logic [31:0] s;
      int n;
      n = 0;
      s = 0;
      while (s[i] !== 1'b1 && n < 80) begin
         repeat (10) @(posedge core_clk);
         wb(ADR_STATUS, 1'b0, 0, s);
         n++;
      end
      chk(s[i], 1, "status bit");
      if (s[i] !== 1'b1) stop_test();
      wb(ADR_STATUS, 1'b1, 32'h1 << i, s);
   endtask
   task automatic wait_peer(input int k);
      int n;
      n = 0;
      while (peer.got.size() < k && n < 2000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 2000) begin
         chk(0, 1, "peer timeout");
         stop_test();
      end
   endtask
   initial begin
      rnd = $urandom(32'hb4d2763f);
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      chk(txd, 1, "idle line");
      chk(txDrvEn, 1, "full duplex driver");
      chk(irq, 0, "irq at reset");
      wb(ADR_CTRL, 1'b0, 0, r);
      chk(r, 0, "ctrl reset");
      wb(8'h3c, 1'b0, 0, r);
      chk(r, 0, "unmapped read");
      $display("reset test done");
      // 115200, 8 bits, one terminator character
      t = 8'($urandom);
      wb(ADR_CHARS, 1'b1, {16'h0, t, 8'h00}, r);
      wb(ADR_CTRL, 1'b1, 32'h041c, r);
      wb(ADR_TXLEN, 1'b1, 32'h2, r);
      for (int i = 0; i < 2; i++) begin
         q.push_back(8'($urandom));
         wb(ADR_TXDATA, 1'b1, {24'h0, q[i]}, r);
      end
      wb(ADR_CTRL, 1'b1, 32'h141c, r);
      wait_peer(3);
      chk(peer.got.size(), 3, "sent count");
      chk(peer.got[0], q[0], "sent byte 0");
      chk(peer.got[1], q[1], "sent byte 1");
      chk(peer.got[2], t, "terminator");
      poll(ST_TXDONE);
      $display("send test done");
      // three characters, none equal to the terminator
      q.delete();
      wb(ADR_RXLEN, 1'b1, 32'h3, r);
      for (int i = 0; i < 3; i++) begin
         q.push_back(8'($urandom));
         if (q[i] == t) q[i] = ~t;
         @(posedge core_clk);
         peer.send_byte(q[i]);
      end
      repeat (20) @(posedge core_clk);
      chk(irq, 0, "masked status");
      wb(ADR_LEVEL, 1'b0, 0, r);
      chk(r[13:0], 3, "fifo count");
      wb(ADR_MASK, 1'b1, 32'h1, r);
      repeat (3) @(posedge core_clk);
      chk(irq, 1, "irq raised");
      poll(ST_RXDONE);
      repeat (3) @(posedge core_clk);
      chk(irq, 0, "irq cleared");
      for (int i = 0; i < 3; i++) begin
         wb(ADR_RXDATA, 1'b0, 0, r);
         chk(r[7:0], q[i], "fifo byte");
      end
      $display("receive test done");
      // gap of 2 ms after a lone character
      wb(ADR_RXLEN, 1'b1, 32'h8, r);
      wb(ADR_GAP, 1'b1, 32'h2, r);
      @(posedge core_clk);
      peer.send_byte(~t);
      poll(ST_GAP);
      $display("gap test done");
      // even parity expected, far end puts its stop bit there
      wb(ADR_CTRL, 1'b1, 32'h043c, r);
      @(posedge core_clk);
      peer.send_byte(8'h00);
      poll(ST_ERR);
      $display("parity test done");
      wb(ADR_BRK, 1'b1, 32'h2, r);
      wb(ADR_CTRL, 1'b1, 32'h251c, r);
      repeat (5) @(posedge core_clk);
      chk(txd, 0, "break low");
      chk(txDrvEn, 1, "half duplex break drive");
      poll(ST_BRKDONE);
      chk(txd, 1, "break over");
      chk(txDrvEn, 0, "half duplex idle");
      $display("break test done");
      stop_test();
   end
endmodule
`default_nettype wire
